// File: counter_glue_pkg.sv
package counter_glue_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PRIME_PULSE_NS = 100;
    localparam int PRIME_PULSE_CYC = (PRIME_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_DEBOUNCE_NS = 1000000;
    localparam int HOLD_DEBOUNCE_CYC = (HOLD_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Dividers
    // ****************************************
    localparam int PRESCALE_FIRST = 10;
    localparam int PRESCALE_SECOND = 2;
    localparam int TIMEBASE_DIV = 2;

    // ****************************************
    // Strobe routing
    // ****************************************
    localparam int STROBE_COUNT = 8;
    localparam logic [2:0] AUX_RANGE_DIGIT = 3'h0;
    localparam logic [2:0] AUX_POINT_DIGIT = 3'h2;
    localparam logic [2:0] DIGIT_FREQUENCY = 3'h0;
    localparam logic [2:0] DIGIT_PERIOD = 3'h1;
    localparam logic [2:0] DIGIT_FUNCTION_B = 3'h2;
    localparam logic [2:0] DIGIT_INTERVAL = 3'h3;
    localparam logic [2:0] DIGIT_EVENT = 3'h4;
    localparam logic [2:0] DIGIT_SELF_CHECK = 3'h7;
    localparam logic [2:0] POINT_SHIFT = 3'h1;

    typedef enum logic [2:0] {
        func_frequency,
        func_period,
        function_b,
        func_interval,
        event_mode_a,
        func_self_check
    } function_type;

    typedef enum logic [1:0] {
        prime_idle,
        prime_armed,
        prime_a_low,
        prime_b_low
    } prime_state_type;

endpackage

// File: div_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface div_link_if;
    logic tick;
    logic q;
    modport src (output tick, input q);
    modport div (input tick, output q);
endinterface
`default_nettype wire

// File: pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] raw, // Pin levels
    output logic [WIDTH-1:0] sync // Synchronised levels
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            sync <= '0;
        end else if (ce) begin
            stage1 <= raw;
            sync <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: edge_divider.sv
`timescale 1ns/1ps
`default_nettype none
module edge_divider #(
    parameter int HALF = 1
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic ce, // Clock enable
    div_link_if.div link // Tick in, divided level out
);
    localparam int CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);
    logic [CW-1:0] count;
    logic q_reg;

    // Output toggles every HALF ticks, so the period is 2*HALF ticks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            q_reg <= 1'b0;
        end else if (ce && link.tick) begin
            if (count == LAST) begin
                count <= '0;
                q_reg <= ~q_reg;
            end else begin
                count <= count + CW'(1);
            end
        end
    end

    assign link.q = q_reg;
endmodule
`default_nettype wire

// File: counter_input_and_strobe_control.sv
// Notes on behaviour
// (R1) Slope switch XORs each squared channel; code skips the XOR on the fast prescaled A path
// (R2) External gate input gates channel A; code gates only the slow path, not the fast prescaled path
// (R3) Undriven external gate reads as high
// (R4) Counter primed by A fall then B fall
// (R5) Arm button lowers priming node, interval only
// (R6) Arm release pulses A then B low
// (R7) Channel A prescaled by ten then two
// (R8) Prescaled A only in fast range
// (R9) Fast range halves returned timebase
// (R10) Divide-by-ten compensated by point shift
// (R11) Counter scans strobes one-hot in sequence
// (R12) Control inputs take their routed strobe
// (R13) Function input gets one strobe of six
// (R14) Resolution input gets gate-selected strobe
// (R15) Fast range routes first strobe to aux
// (R16) Fast non-function_b non-event routes third strobe
// (R17) Counter places point at routed strobe
// (R18) Oscillator input internal or external source
// (R19) Debounced hold commands display hold
// (R20) Event mode hold or gate stops counting; code stops only the slow path, the fast prescaled path ignores both
// (R21) Fast path divides by twenty, slow slope-gated
// (R22) Routing follows synchronised settings within scan
`timescale 1ns/1ps
`default_nettype none
module counter_input_and_strobe_control #(
    parameter int HOLD_DEBOUNCE_CYC = counter_glue_pkg::HOLD_DEBOUNCE_CYC
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst, // Async reset, high
    input wire logic ce, // Clock enable
    input wire logic chan_a_squared, // Squared channel A
    input wire logic chan_b_squared, // Squared channel B
    input wire logic slope_a_invert, // A slope switch
    input wire logic slope_b_invert, // B slope switch
    input wire logic external_count_gate, // Gate input level
    input wire logic external_count_gate_driven, // Something drives gate
    input wire logic hold_switch, // Raw hold switch
    input wire logic arm_button, // Interval arm button
    input wire logic fast_range_setting, // High-frequency range
    input wire logic [2:0] function_select, // Function switch
    input wire logic [1:0] gate_select, // Gate time switch
    input wire logic timebase_source_switch, // High selects external
    input wire logic internal_osc, // Crystal oscillator
    input wire logic external_osc, // External 10 MHz
    input wire logic [7:0] digit_scan_strobes, // Counter strobes
    input wire logic buffered_timebase_output, // Counter 5 MHz out
    output logic counter_input_a, // To counter input A
    output logic counter_input_b, // To counter input B
    output logic function_ctl, // Function-select input
    output logic resolution_ctl, // Resolution-select input
    output logic aux_ctl, // Auxiliary control input
    output logic point_position_input, // Point-position input
    output logic alternate_timebase_input, // Alternate timebase input
    output logic osc_drive, // Oscillator input
    output logic display_hold_cmd // Display hold command
);
    // ****************************************
    // Pin synchronisation
    // ****************************************
    localparam int SW = 26;
    logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_s;
    logic a_s, b_s, slope_a_s, slope_b_s, gate_s, gate_drv_s, hold_s, arm_s;
    logic fast_s, src_s, int_osc_s, ext_osc_s, tb_s;
    logic [2:0] func_raw_s;
    logic [1:0] gate_sel_s;
    logic [7:0] strobe_s;

    assign pins_raw = {chan_a_squared, chan_b_squared, slope_a_invert, slope_b_invert,
        external_count_gate, external_count_gate_driven, hold_switch, arm_button,
        fast_range_setting, function_select, gate_select, timebase_source_switch,
        internal_osc, external_osc, digit_scan_strobes, buffered_timebase_output};

    pin_sync #(.WIDTH(SW)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .raw(pins_raw),
        .sync(pins_s)
    );

    assign {a_s, b_s, slope_a_s, slope_b_s, gate_s, gate_drv_s, hold_s, arm_s,
        fast_s, func_raw_s, gate_sel_s, src_s, int_osc_s, ext_osc_s, strobe_s, tb_s} = pins_s;

    wire counter_glue_pkg::function_type func_s = counter_glue_pkg::function_type'(func_raw_s);
    wire is_event = (func_s == counter_glue_pkg::event_mode_a);
    wire is_function_b = (func_s == counter_glue_pkg::function_b);
    wire is_interval = (func_s == counter_glue_pkg::func_interval);

    // ****************************************
    // Hold debounce
    // ****************************************
    localparam int DW = $clog2(HOLD_DEBOUNCE_CYC + 1);
    localparam logic [DW-1:0] DEB_LAST = DW'(HOLD_DEBOUNCE_CYC - 1);
    logic [DW-1:0] deb_count;
    logic hold_stable;
    wire hold_differs = (hold_s != hold_stable);

    // Level accepted only after it stays put for the full window
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            deb_count <= '0;
            hold_stable <= 1'b0;
        end else if (ce) begin
            if (!hold_differs) begin
                deb_count <= '0;
            end else if (deb_count == DEB_LAST) begin
                deb_count <= '0;
                hold_stable <= hold_s; // R19
            end else begin
                deb_count <= deb_count + DW'(1);
            end
        end
    end

    // ****************************************
    // Slope select and gating
    // ****************************************
    wire gate_eff = gate_drv_s ? gate_s : 1'b1; // R3
    wire hold_cut = is_event && hold_stable; // R20
    wire a_slope = a_s ^ slope_a_s; // R1
    wire b_slope = b_s ^ slope_b_s; // R1
    wire a_gated = a_slope && gate_eff && !hold_cut; // R2 R20

    // ****************************************
    // Interval priming
    // ****************************************
    localparam int PW = $clog2(counter_glue_pkg::PRIME_PULSE_CYC + 1);
    localparam logic [PW-1:0] PULSE_LAST = PW'(counter_glue_pkg::PRIME_PULSE_CYC - 1);
    counter_glue_pkg::prime_state_type prime_state;
    counter_glue_pkg::prime_state_type next_prime_state;
    logic [PW-1:0] pulse_count;
    wire pulse_done = (pulse_count == PULSE_LAST);

    // Arm only acts in interval mode; the release sequence always completes
    always_comb begin
        next_prime_state = prime_state;
        case (prime_state)
            counter_glue_pkg::prime_idle: begin
                if (arm_s && is_interval) begin
                    next_prime_state = counter_glue_pkg::prime_armed; // R5
                end
            end
            counter_glue_pkg::prime_armed: begin
                if (!arm_s) begin
                    next_prime_state = counter_glue_pkg::prime_a_low; // R6
                end
            end
            counter_glue_pkg::prime_a_low: begin
                if (pulse_done) begin
                    next_prime_state = counter_glue_pkg::prime_b_low; // R4
                end
            end
            counter_glue_pkg::prime_b_low: begin
                if (pulse_done) begin
                    next_prime_state = counter_glue_pkg::prime_idle; // R6
                end
            end
            default: begin
                next_prime_state = counter_glue_pkg::prime_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prime_state <= counter_glue_pkg::prime_idle;
            pulse_count <= '0;
        end else if (ce) begin
            prime_state <= next_prime_state;
            pulse_count <= (next_prime_state != prime_state) ? '0 : pulse_count + PW'(1);
        end
    end

    // Armed holds both lines high so the release gives clean falls
    wire primed_a = (prime_state == counter_glue_pkg::prime_idle) ? a_gated :
        (prime_state != counter_glue_pkg::prime_a_low);
    wire primed_b = (prime_state == counter_glue_pkg::prime_idle) ? b_slope :
        (prime_state != counter_glue_pkg::prime_b_low);

    // ****************************************
    // Prescaler and timebase halving
    // ****************************************
    div_link_if link_ten ();
    div_link_if link_two ();
    div_link_if link_tb ();
    logic a_prev, ten_prev, tb_prev;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            a_prev <= 1'b0;
            ten_prev <= 1'b0;
            tb_prev <= 1'b0;
        end else if (ce) begin
            a_prev <= a_s;
            ten_prev <= link_ten.q;
            tb_prev <= tb_s;
        end
    end

    // Prescaler taps the squared signal ahead of slope and gate
    assign link_ten.tick = a_s && !a_prev; // R7
    assign link_two.tick = link_ten.q && !ten_prev; // R7
    assign link_tb.tick = tb_s && !tb_prev; // R9

    edge_divider #(.HALF(counter_glue_pkg::PRESCALE_FIRST / 2)) u_div_ten (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .link(link_ten)
    );

    edge_divider #(.HALF(counter_glue_pkg::PRESCALE_SECOND / 2)) u_div_two (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .link(link_two)
    );

    edge_divider #(.HALF(counter_glue_pkg::TIMEBASE_DIV / 2)) u_div_tb (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .link(link_tb)
    );

    // ****************************************
    // Strobe routing
    // ****************************************
    // Each strobe is high alone, so one index picks one digit
    wire [2:0] func_digit = (func_s == counter_glue_pkg::func_period) ?
        counter_glue_pkg::DIGIT_PERIOD :
        is_function_b ? counter_glue_pkg::DIGIT_FUNCTION_B :
        is_interval ? counter_glue_pkg::DIGIT_INTERVAL :
        is_event ? counter_glue_pkg::DIGIT_EVENT :
        (func_s == counter_glue_pkg::func_self_check) ? counter_glue_pkg::DIGIT_SELF_CHECK :
        counter_glue_pkg::DIGIT_FREQUENCY; // R13
    wire time_like = (func_s == counter_glue_pkg::func_period) || is_interval;
    // Point moves one digit in the fast range, except in period and interval, to undo the divide by ten
    wire [2:0] point_digit = {1'b0, gate_sel_s} +
        (time_like ? 3'h0 : counter_glue_pkg::POINT_SHIFT); // R10 R17
    wire point_enable = fast_s && !is_function_b && !is_event; // R16
    wire next_function = strobe_s[func_digit]; // R11 R13
    wire next_resolution = strobe_s[{1'b0, gate_sel_s}]; // R14
    wire next_aux = (fast_s && strobe_s[counter_glue_pkg::AUX_RANGE_DIGIT]) ||
        (point_enable && strobe_s[counter_glue_pkg::AUX_POINT_DIGIT]); // R15 R16
    wire next_point = point_enable && strobe_s[point_digit]; // R10
    wire next_a = fast_s ? link_two.q : primed_a; // R8 R21
    wire next_alt_tb = fast_s && link_tb.q; // R9
    wire next_osc = src_s ? ext_osc_s : int_osc_s; // R18

    // ****************************************
    // Output registers
    // ****************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            counter_input_a <= 1'b0;
            counter_input_b <= 1'b0;
            function_ctl <= 1'b0;
            resolution_ctl <= 1'b0;
            aux_ctl <= 1'b0;
            point_position_input <= 1'b0;
            alternate_timebase_input <= 1'b0;
            osc_drive <= 1'b0;
            display_hold_cmd <= 1'b0;
        end else if (ce) begin
            counter_input_a <= next_a; // R8
            counter_input_b <= primed_b; // R1
            function_ctl <= next_function; // R12 R22
            resolution_ctl <= next_resolution; // R12 R22
            aux_ctl <= next_aux; // R12
            point_position_input <= next_point; // R17
            alternate_timebase_input <= next_alt_tb; // R9
            osc_drive <= next_osc; // R18
            display_hold_cmd <= hold_stable; // R19
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_a_pulse;
        prime_state == counter_glue_pkg::prime_a_low && pulse_count == '0;
    endsequence

    sequence s_b_begin;
        prime_state == counter_glue_pkg::prime_b_low && pulse_count == '0;
    endsequence

    property p_release_sequence;
        (prime_state == counter_glue_pkg::prime_armed && !arm_s && ce) |=> s_a_pulse;
    endproperty
    a_release_sequence: assert property (p_release_sequence) else $error("priming order wrong"); // R6

    // Pulse length checked on the counter, too long to unroll
    property p_a_pulse_hold;
        (ce && prime_state == counter_glue_pkg::prime_a_low && !pulse_done) |=>
            prime_state == counter_glue_pkg::prime_a_low;
    endproperty
    a_a_pulse_hold: assert property (p_a_pulse_hold) else $error("a pulse ended early"); // R6

    property p_a_pulse_end;
        (ce && prime_state == counter_glue_pkg::prime_a_low && pulse_done) |=> s_b_begin;
    endproperty
    a_a_pulse_end: assert property (p_a_pulse_end) else $error("b pulse did not follow"); // R4

    property p_arm_needs_interval;
        (ce && prime_state == counter_glue_pkg::prime_idle && !is_interval) |=>
            prime_state == counter_glue_pkg::prime_idle;
    endproperty
    a_arm_needs_interval: assert property (p_arm_needs_interval) else $error("arm outside interval"); // R5

    property p_slow_slope;
        (ce && !fast_s && prime_state == counter_glue_pkg::prime_idle && gate_eff && !hold_cut)
            |=> counter_input_a == $past(a_s ^ slope_a_s);
    endproperty
    a_slow_slope: assert property (p_slow_slope) else $error("slope path wrong"); // R1

    property p_gate_blocks;
        (ce && !fast_s && prime_state == counter_glue_pkg::prime_idle &&
            (gate_drv_s && !gate_s)) |=> !counter_input_a;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("gate did not block"); // R2

    property p_hold_cuts_event;
        (ce && !fast_s && is_event && hold_stable &&
            prime_state == counter_glue_pkg::prime_idle) |=> !counter_input_a;
    endproperty
    a_hold_cuts_event: assert property (p_hold_cuts_event) else $error("hold did not cut"); // R20

    property p_fast_path;
        (ce && fast_s) |=> counter_input_a == $past(link_two.q);
    endproperty
    a_fast_path: assert property (p_fast_path) else $error("prescaled path missing"); // R8

    property p_slow_no_alt_tb;
        (ce && !fast_s) |=> !alternate_timebase_input && !aux_ctl && !point_position_input;
    endproperty
    a_slow_no_alt_tb: assert property (p_slow_no_alt_tb) else $error("fast routing in slow"); // R9

    property p_aux_range;
        (ce && fast_s && strobe_s[counter_glue_pkg::AUX_RANGE_DIGIT]) |=> aux_ctl;
    endproperty
    a_aux_range: assert property (p_aux_range) else $error("aux range strobe missing"); // R15

    property p_event_function;
        (ce && is_event && strobe_s == 8'h10) |=> function_ctl && !resolution_ctl;
    endproperty
    a_event_function: assert property (p_event_function) else $error("function strobe wrong"); // R13

    property p_hold_follows;
        (ce && hold_stable) |=> display_hold_cmd;
    endproperty
    a_hold_follows: assert property (p_hold_follows) else $error("hold not commanded"); // R19

endmodule
`default_nettype wire

// File: counter_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module counter_core_model #(
    parameter int DWELL = 10
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Async reset
    output logic [7:0] digit_scan_strobes, // One-hot strobes
    output logic buffered_timebase_output // 5 MHz timebase
);
    // ****************************************
    // Scan and timebase
    // ****************************************
    int dwell_count;
    int tb_count;

    // Dwell long enough that routed copies settle while a strobe is up
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            digit_scan_strobes <= 8'h01;
            dwell_count <= 0;
            tb_count <= 0;
            buffered_timebase_output <= 1'b0;
        end else begin
            dwell_count <= (dwell_count == DWELL - 1) ? 0 : dwell_count + 1;
            if (dwell_count == DWELL - 1) begin
                digit_scan_strobes <= {digit_scan_strobes[6:0], digit_scan_strobes[7]};
            end
            tb_count <= (tb_count == 9) ? 0 : tb_count + 1;
            if (tb_count == 9) begin
                buffered_timebase_output <= ~buffered_timebase_output;
            end
        end
    end
endmodule
`default_nettype wire

// File: test_counter_input_and_strobe_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("wrong value %s expected %0h seen %0h", name, exp, got); \
    end \
end
module test_counter_input_and_strobe_control;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic chan_a_squared = 1'b0;
    logic chan_b_squared = 1'b0;
    logic slope_a_invert = 1'b0;
    logic slope_b_invert = 1'b0;
    logic external_count_gate = 1'b1;
    logic external_count_gate_driven = 1'b1;
    logic hold_switch = 1'b0;
    logic arm_button = 1'b0;
    logic fast_range_setting = 1'b0;
    logic [2:0] function_select = 3'h0;
    logic [1:0] gate_select = 2'h0;
    logic timebase_source_switch = 1'b0;
    logic internal_osc = 1'b0;
    logic external_osc = 1'b0;
    wire logic [7:0] digit_scan_strobes;
    wire logic buffered_timebase_output;
    wire logic counter_input_a, counter_input_b, function_ctl, resolution_ctl;
    wire logic aux_ctl, point_position_input, alternate_timebase_input;
    wire logic osc_drive, display_hold_cmd;
    int failures = 0;
    int check_count = 0;
    int n;
    logic tb_last;

    counter_input_and_strobe_control #(.HOLD_DEBOUNCE_CYC(4)) DUT (
        .ref_clk, .rst, .ce, .chan_a_squared, .chan_b_squared, .slope_a_invert,
        .slope_b_invert, .external_count_gate, .external_count_gate_driven, .hold_switch,
        .arm_button, .fast_range_setting, .function_select, .gate_select,
        .timebase_source_switch, .internal_osc, .external_osc, .digit_scan_strobes,
        .buffered_timebase_output, .counter_input_a, .counter_input_b, .function_ctl,
        .resolution_ctl, .aux_ctl, .point_position_input, .alternate_timebase_input,
        .osc_drive, .display_hold_cmd
    );
    counter_core_model partner (
        .ref_clk, .rst, .digit_scan_strobes, .buffered_timebase_output
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    // Edges seen on counter input A while channel A makes the given rises
    task automatic toggles(input int rises, output int t);
        logic last;
        t = 0;
        last = counter_input_a;
        for (int i = 0; i < 2 * rises + 4; i++) begin
            @(posedge ref_clk);
            if (i < 2 * rises) chan_a_squared <= ~chan_a_squared;
            repeat (4) begin
                tick(1);
                if (counter_input_a !== last) t++;
                last = counter_input_a;
            end
        end
    endtask

    task automatic low_run(input logic sel_b, output int t);
        t = 0;
        for (int i = 0; i < 30 && (sel_b ? counter_input_b : counter_input_a) !== 1'b0; i++)
            tick(1);
        while ((sel_b ? counter_input_b : counter_input_a) === 1'b0 && t < 40) begin
            t++;
            tick(1);
        end
    endtask

    task automatic wait_strobe(input int k);
        for (int i = 0; i < 200 && digit_scan_strobes[k] !== 1'b1; i++) tick(1);
    endtask

    task automatic routes(input logic f, input logic [2:0] fn, input logic [1:0] g);
        logic pe;
        logic [2:0] fd;
        logic [2:0] pd;
        @(posedge ref_clk);
        fast_range_setting <= f;
        function_select <= fn;
        gate_select <= g;
        pe = f && fn != 3'h2 && fn != 3'h4;
        fd = (fn == 3'h5) ? counter_glue_pkg::DIGIT_SELF_CHECK : fn;
        pd = {1'b0, g} + ((fn == 3'h1 || fn == 3'h3) ? 3'h0 : 3'h1);
        tick(6);
        wait_strobe(7);
        for (int k = 0; k < 8; k++) begin
            wait_strobe(k);
            tick(5);
            `CHECK("function_ctl", fd == k, function_ctl)
            `CHECK("resolution_ctl", g == k, resolution_ctl)
            `CHECK("aux_ctl", f && (k == 0 || (pe && k == 2)), aux_ctl)
            `CHECK("point", pe && pd == k, point_position_input)
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #800000;
        failures++;
        close_out();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        tick(6);
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            {slope_a_invert, chan_a_squared} <= i[1:0];
            {slope_b_invert, chan_b_squared} <= ~i[1:0];
            tick(6);
            `CHECK("slope a", i[0] ^ i[1], counter_input_a)
            `CHECK("slope b", i[0] ^ i[1], counter_input_b)
        end
        @(posedge ref_clk);
        {slope_a_invert, chan_a_squared, slope_b_invert} <= 3'h0;
        tick(6);
        toggles(20, n);
        `CHECK("slow edges", 40, n)
        external_count_gate <= 1'b0;
        toggles(20, n);
        `CHECK("gated edges", 0, n)
        external_count_gate_driven <= 1'b0;
        toggles(20, n);
        `CHECK("undriven gate edges", 40, n)
        external_count_gate_driven <= 1'b1;
        fast_range_setting <= 1'b1;
        toggles(20, n);
        `CHECK("prescaled edges", 2, n)
        fast_range_setting <= 1'b0;
        external_count_gate <= 1'b1;
        hold_switch <= 1'b1;
        tick(2);
        hold_switch <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            tick(1);
            `CHECK("hold glitch", 1'b0, display_hold_cmd)
        end
        hold_switch <= 1'b1;
        tick(14);
        `CHECK("hold cmd", 1'b1, display_hold_cmd)
        toggles(20, n);
        `CHECK("hold freq edges", 40, n)
        function_select <= 3'h4;
        toggles(20, n);
        `CHECK("hold event edges", 0, n)
        hold_switch <= 1'b0;
        tick(14);
        `CHECK("hold released", 1'b0, display_hold_cmd)
        external_count_gate <= 1'b0;
        toggles(20, n);
        `CHECK("gate event edges", 0, n)
        external_count_gate <= 1'b1;
        for (int f = 1; f >= 0; f--) begin
            @(posedge ref_clk);
            fast_range_setting <= f[0];
            tick(8);
            n = 0;
            tb_last = alternate_timebase_input;
            for (int i = 0; i < 200; i++) begin
                tick(1);
                if (alternate_timebase_input !== tb_last) n++;
                tb_last = alternate_timebase_input;
            end
            `CHECK("timebase edges", f ? 10 : 0, n)
        end
        `CHECK("timebase idle", 1'b0, alternate_timebase_input)
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            timebase_source_switch <= i[1];
            internal_osc <= i[0];
            external_osc <= ~i[0];
            tick(6);
            `CHECK("osc_drive", i[1] ^ i[0], osc_drive)
        end
        ce <= 1'b0;
        external_osc <= 1'b1;
        tick(6);
        `CHECK("frozen osc", 1'b0, osc_drive)
        ce <= 1'b1;
        tick(6);
        `CHECK("thawed osc", 1'b1, osc_drive)
        @(posedge ref_clk);
        function_select <= 3'h3;
        {chan_a_squared, chan_b_squared} <= 2'h0;
        tick(6);
        arm_button <= 1'b1;
        tick(8);
        `CHECK("armed a", 1'b1, counter_input_a)
        `CHECK("armed b", 1'b1, counter_input_b)
        {arm_button, chan_a_squared, chan_b_squared} <= 3'h3;
        low_run(1'b0, n);
        `CHECK("prime a low", counter_glue_pkg::PRIME_PULSE_CYC, n)
        low_run(1'b1, n);
        `CHECK("prime b low", counter_glue_pkg::PRIME_PULSE_CYC, n)
        function_select <= 3'h0;
        tick(6);
        arm_button <= 1'b1;
        tick(8);
        arm_button <= 1'b0;
        low_run(1'b0, n);
        `CHECK("arm ignored", 0, n)
        for (int f = 0; f < 6; f++) begin
            routes(1'b1, f[2:0], f[1:0]);
            routes(1'b0, f[2:0], ~f[1:0]);
        end
        close_out();
    end
endmodule
`default_nettype wire
